// file: rtl/pmt_defs.svh
// Purpose: Offsets, field positions, reset values and counts of the timer
// Assumes: Included by every timer file except the package
// Notes: Definitions only
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH
// Register byte offsets
`define PMT_OFF_COUNT 8'h00
`define PMT_OFF_LIMIT 8'h04
`define PMT_OFF_CTRL 8'h08
`define PMT_OFF_FLAG 8'h0c
`define PMT_OFF_MASK 8'h10
// Control register fields, then the flag and mask bit
`define PMT_CTRL_POST_HI 6
`define PMT_CTRL_POST_LO 3
`define PMT_CTRL_RUN 2
`define PMT_CTRL_PRE_HI 1
`define PMT_CTRL_PRE_LO 0
`define PMT_FLAG_BIT 0
// Reset values
`define PMT_RST_COUNT 8'h00
`define PMT_RST_LIMIT 8'hff
`define PMT_RST_POST 4'h0
`define PMT_RST_PRE 2'h0
// Instruction clock is the system clock over four
`define PMT_INST_LAST 2'h3
// Last prescaler count for each divide ratio
`define PMT_PRE_LAST1 6'h00
`define PMT_PRE_LAST4 6'h03
`define PMT_PRE_LAST16 6'h0f
`define PMT_PRE_LAST64 6'h3f
`endif

// file: rtl/pmt_pkg.sv
// Purpose: State types of the period match timer
// Assumes: Constants live in pmt_defs.svh
// Notes: One packed struct per module
package pmt_pkg;
   typedef enum logic [1:0] {
      PMT_PRE_DIV1 = 2'h0,
      PMT_PRE_DIV4 = 2'h1,
      PMT_PRE_DIV16 = 2'h2,
      PMT_PRE_DIV64 = 2'h3
   } pmt_pre_sel_t;
   typedef struct packed {
      logic [1:0] inst;
      logic [5:0] cnt;
   } pmt_pre_state_t;
   typedef struct packed {
      logic [3:0] cnt;
   } pmt_post_state_t;
   typedef struct packed {
      logic [7:0] count;
      logic [7:0] limit;
      logic [3:0] post_sel;
      logic run;
      pmt_pre_sel_t pre_sel;
      logic flag;
      logic mask;
      logic [31:0] rdata;
      logic slverr;
   } pmt_regs_t;
endpackage

// file: rtl/pmt_postscaler.sv
// Purpose: Counts comparator matches, one pulse per select plus one
// Assumes: match is a one-cycle pulse
// Notes: clear wins over a match for the count, but pulse is not gated by clear
`timescale 1ns/1ns
`include "pmt_defs.svh"
module pmt_postscaler (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic clear,
   input wire logic match,
   input wire logic [3:0] sel,
   // Output
   output logic pulse
);
   import pmt_pkg::*;
   pmt_post_state_t s_q, s_d;
   assign pulse = match && (s_q.cnt == sel);
   // Advance per match, wrap after sel plus one matches
   always_comb begin
      s_d = s_q;
      if (clear) s_d.cnt = 4'h0;
      else if (pulse) s_d.cnt = 4'h0;
      else if (match) s_d.cnt = s_q.cnt + 4'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s_q <= '0;
      else s_q <= s_d;
   end
   property p_advance;
      @(posedge pclk) disable iff (!presetn)
         (match && !pulse && !clear) |=> s_q.cnt == $past(s_q.cnt) + 4'h1;
   endproperty
   a_advance: assert property (p_advance)
      else $error("postscaler did not advance on match");
endmodule

// file: rtl/pmt_prescaler.sv
// Purpose: Instruction clock divider and 1/4/16/64 prescaler
// Assumes: clear has priority over counting
// Notes: tick is a one-cycle enable, never a clock
`timescale 1ns/1ns
`include "pmt_defs.svh"
module pmt_prescaler (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Control
   input wire logic run,
   input wire logic clear,
   input wire pmt_pkg::pmt_pre_sel_t sel,
   // Output enables
   output logic inst_en,
   output logic tick
);
   import pmt_pkg::*;
   pmt_pre_state_t s_q, s_d;
   logic [5:0] last;
   // Divide ratio to last count
   always_comb begin
      case (sel)
         PMT_PRE_DIV1: last = `PMT_PRE_LAST1;
         PMT_PRE_DIV4: last = `PMT_PRE_LAST4;
         PMT_PRE_DIV16: last = `PMT_PRE_LAST16;
         default: last = `PMT_PRE_LAST64;
      endcase
   end
   // A clear suppresses the tick so a write never races an increment
   assign inst_en = run && (s_q.inst == `PMT_INST_LAST);
   assign tick = inst_en && !clear && (s_q.cnt >= last);
   // Next state
   always_comb begin
      s_d = s_q;
      if (clear) begin
         s_d = '0;
      end else if (run) begin
         s_d.inst = s_q.inst + 2'h1;
         if (inst_en) begin
            s_d.cnt = (s_q.cnt >= last) ? 6'h00 : s_q.cnt + 6'h01;
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) s_q <= '0;
      else s_q <= s_d;
   end
   property p_inst_gap;
      @(posedge pclk) disable iff (!presetn) inst_en |=> !inst_en [*3];
   endproperty
   a_inst_gap: assert property (p_inst_gap)
      else $error("instruction enable closer than four cycles");
   property p_div64_gap;
      @(posedge pclk) disable iff (!presetn)
         (tick && sel == PMT_PRE_DIV64) |=> !tick [*8];
   endproperty
   a_div64_gap: assert property (p_div64_gap)
      else $error("prescaler tick too soon at divide by 64");
   property p_clear;
      @(posedge pclk) disable iff (!presetn) clear |=> s_q.cnt == 6'h00;
   endproperty
   a_clear: assert property (p_clear)
      else $error("prescaler not cleared");
endmodule

// file: rtl/pmt_timer.sv
// Purpose: Period match timer with APB register access and interrupt
// Assumes: pclk is the system oscillator, 100 MHz; APB3 without pstrb
// Notes: Zero wait state slave; read data captured in the setup cycle
`timescale 1ns/1ns
`include "pmt_defs.svh"
module pmt_timer #(
   parameter int ADDR_W = 8
) (
   // APB clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   // APB answer
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   // Interrupt
   output logic irq
);
   import pmt_pkg::*;

   pmt_regs_t r_q, r_d;

   // Bus strobes; the slave never stretches the access phase
   logic setup;
   logic wr;
   logic [7:0] addr;
   logic hit_count, hit_limit, hit_ctrl, hit_flag, hit_mask;
   logic mapped;
   logic wr_count, wr_limit, wr_ctrl, wr_flag, wr_mask;

   // Timer datapath
   logic clear;
   logic inst_en;
   logic tick;
   logic equal;
   logic match;
   logic post_pulse;
   logic [7:0] ctrl_view;

   assign pready = 1'b1;
   assign setup = psel && !penable;
   assign wr = psel && penable && pwrite;
   assign addr = paddr[7:0];

   // Address decode
   always_comb begin
      hit_count = 1'b0;
      hit_limit = 1'b0;
      hit_ctrl = 1'b0;
      hit_flag = 1'b0;
      hit_mask = 1'b0;
      if (addr == `PMT_OFF_COUNT) begin
         hit_count = 1'b1;
      end else if (addr == `PMT_OFF_LIMIT) begin
         hit_limit = 1'b1;
      end else if (addr == `PMT_OFF_CTRL) begin
         hit_ctrl = 1'b1;
      end else if (addr == `PMT_OFF_FLAG) begin
         hit_flag = 1'b1;
      end else if (addr == `PMT_OFF_MASK) begin
         hit_mask = 1'b1;
      end
   end

   // Upper address bits must be zero so aliases do not answer
   assign mapped = (paddr == ADDR_W'(addr)) &&
      (hit_count || hit_limit || hit_ctrl || hit_flag || hit_mask);

   // Write strobes, one cycle each, in the access phase
   assign wr_count = wr && mapped && hit_count;
   assign wr_limit = wr && mapped && hit_limit;
   assign wr_ctrl = wr && mapped && hit_ctrl;
   assign wr_flag = wr && mapped && hit_flag;
   assign wr_mask = wr && mapped && hit_mask;

   // Control register as software sees it, bit 7 tied low
   always_comb begin
      ctrl_view = 8'h00;
      ctrl_view[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO] = r_q.post_sel;
      ctrl_view[`PMT_CTRL_RUN] = r_q.run;
      ctrl_view[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO] = r_q.pre_sel;
   end

   // Writing the count or the control restarts both scalers
   assign clear = wr_count || wr_ctrl;

   pmt_prescaler u_pre (
      .pclk(pclk),
      .presetn(presetn),
      .run(r_q.run),
      .clear(clear),
      .sel(r_q.pre_sel),
      .inst_en(inst_en),
      .tick(tick)
   );

   // Comparator is purely combinational, so it sees every value
   assign equal = (r_q.count == r_q.limit);
   assign match = tick && equal;

   pmt_postscaler u_post (
      .pclk(pclk),
      .presetn(presetn),
      .clear(clear),
      .match(match),
      .sel(r_q.post_sel),
      .pulse(post_pulse)
   );

   // Register file and count update
   always_comb begin
      r_d = r_q;
      // Count: a software write wins, ticks are suppressed that cycle
      if (wr_count) begin
         r_d.count = pwdata[7:0];
      end else if (match) begin
         r_d.count = 8'h00;
      end else if (tick) begin
         r_d.count = r_q.count + 8'h01;
      end
      if (wr_limit) begin
         r_d.limit = pwdata[7:0];
      end
      // Control write touches only control fields, never the count
      if (wr_ctrl) begin
         r_d.post_sel = pwdata[`PMT_CTRL_POST_HI:`PMT_CTRL_POST_LO];
         r_d.run = pwdata[`PMT_CTRL_RUN];
         r_d.pre_sel =
            pmt_pre_sel_t'(pwdata[`PMT_CTRL_PRE_HI:`PMT_CTRL_PRE_LO]);
      end
      // Flag: write one clears, a pulse in the same cycle wins
      if (wr_flag && pwdata[`PMT_FLAG_BIT]) begin
         r_d.flag = 1'b0;
      end
      if (post_pulse) begin
         r_d.flag = 1'b1;
      end
      if (wr_mask) begin
         r_d.mask = pwdata[`PMT_FLAG_BIT];
      end
      // Read data is fixed in the setup cycle and held for the access
      if (setup) begin
         r_d.rdata = 32'h0000_0000;
         r_d.slverr = !mapped;
         if (!pwrite && mapped) begin
            if (hit_count) begin
               r_d.rdata[7:0] = r_q.count;
            end else if (hit_limit) begin
               r_d.rdata[7:0] = r_q.limit;
            end else if (hit_ctrl) begin
               r_d.rdata[7:0] = ctrl_view;
            end else if (hit_flag) begin
               r_d.rdata[`PMT_FLAG_BIT] = r_q.flag;
            end else begin
               r_d.rdata[`PMT_FLAG_BIT] = r_q.mask;
            end
         end
      end
   end

   // All state resets together; limit resets high so the first period
   // is the longest one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
         r_q.count <= `PMT_RST_COUNT;
         r_q.limit <= `PMT_RST_LIMIT;
         r_q.post_sel <= `PMT_RST_POST;
         r_q.pre_sel <= pmt_pre_sel_t'(`PMT_RST_PRE);
         r_q.run <= 1'b0;
      end else begin
         r_q <= r_d;
      end
   end

   // Answer and interrupt
   assign prdata = r_q.rdata;
   assign pslverr = r_q.slverr;
   assign irq = r_q.flag && r_q.mask;

   // Checks on the timer datapath

   sequence s_tick_no_write;
      tick && !wr_count;
   endsequence

   property p_increment;
      @(posedge pclk) disable iff (!presetn)
         (s_tick_no_write and !equal) |=>
            r_q.count == $past(r_q.count) + 8'h01;
   endproperty
   a_increment: assert property (p_increment)
      else $error("count did not increment on tick");

   property p_wrap;
      @(posedge pclk) disable iff (!presetn)
         (s_tick_no_write and equal) |=> r_q.count == 8'h00;
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("count did not reload zero after match");

   property p_no_tick_no_move;
      @(posedge pclk) disable iff (!presetn)
         (!tick && !wr_count) |=> $stable(r_q.count);
   endproperty
   a_no_tick_no_move: assert property (p_no_tick_no_move)
      else $error("count moved without a tick");

   property p_flag_set;
      @(posedge pclk) disable iff (!presetn) post_pulse |=> r_q.flag;
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("postscaler pulse did not set flag");

   property p_single_post;
      @(posedge pclk) disable iff (!presetn)
         (match && r_q.post_sel == 4'h0 && !clear) |-> post_pulse;
   endproperty
   a_single_post: assert property (p_single_post)
      else $error("postscale of one missed a match");

   property p_count_write;
      @(posedge pclk) disable iff (!presetn)
         wr_count |=> r_q.count == $past(pwdata[7:0]);
   endproperty
   a_count_write: assert property (p_count_write)
      else $error("count write not stored");

   property p_ctrl_keeps_count;
      @(posedge pclk) disable iff (!presetn)
         wr_ctrl |=> $stable(r_q.count);
   endproperty
   a_ctrl_keeps_count: assert property (p_ctrl_keeps_count)
      else $error("control write changed the count");

   sequence s_stopped;
      !r_q.run && !wr_ctrl && !wr_count;
   endsequence

   property p_stopped_hold;
      @(posedge pclk) disable iff (!presetn)
         s_stopped |-> !tick && !post_pulse ##1 $stable(r_q.count);
   endproperty
   a_stopped_hold: assert property (p_stopped_hold)
      else $error("stopped timer moved or pulsed");

   property p_stopped_no_inst;
      @(posedge pclk) disable iff (!presetn) !r_q.run |-> !inst_en;
   endproperty
   a_stopped_no_inst: assert property (p_stopped_no_inst)
      else $error("instruction enable while stopped");

   property p_ctrl_bit7;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && mapped && hit_ctrl) |=> prdata[7] == 1'b0;
   endproperty
   a_ctrl_bit7: assert property (p_ctrl_bit7)
      else $error("control bit 7 read nonzero");

   property p_ctrl_read;
      @(posedge pclk) disable iff (!presetn)
         (setup && !pwrite && mapped && hit_ctrl) |=>
            prdata[1:0] == $past(r_q.pre_sel);
   endproperty
   a_ctrl_read: assert property (p_ctrl_read)
      else $error("prescale select read back wrong");

   // Watches the whole path from pulse through the flag register to irq
   property p_irq;
      @(posedge pclk) disable iff (!presetn)
         (post_pulse && r_q.mask) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt does not follow flag and mask");

   // A clear only loses to a pulse in the same cycle
   property p_flag_clear;
      @(posedge pclk) disable iff (!presetn)
         (wr_flag && pwdata[`PMT_FLAG_BIT] && !post_pulse) |=> !r_q.flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear)
      else $error("flag not cleared by a write of one");

   property p_limit_write;
      @(posedge pclk) disable iff (!presetn)
         wr_limit |=> r_q.limit == $past(pwdata[7:0]);
   endproperty
   a_limit_write: assert property (p_limit_write)
      else $error("limit write not stored");

   // Aliases and holes must answer with an error in the access phase
   property p_unmapped_err;
      @(posedge pclk) disable iff (!presetn)
         (setup && !mapped) |=> pslverr;
   endproperty
   a_unmapped_err: assert property (p_unmapped_err)
      else $error("unmapped access without error");

   property p_div1_tick;
      @(posedge pclk) disable iff (!presetn)
         (inst_en && r_q.pre_sel == PMT_PRE_DIV1 && !clear) |-> tick;
   endproperty
   a_div1_tick: assert property (p_div1_tick)
      else $error("divide by one missed an instruction cycle");

   property p_clear_restart;
      @(posedge pclk) disable iff (!presetn)
         (clear && r_q.pre_sel == PMT_PRE_DIV4) |-> !tick [*4];
   endproperty
   a_clear_restart: assert property (p_clear_restart)
      else $error("tick too soon after scaler clear");

   property p_inst_tick;
      @(posedge pclk) disable iff (!presetn) tick |-> inst_en;
   endproperty
   a_inst_tick: assert property (p_inst_tick)
      else $error("tick outside an instruction cycle");

   property p_match_post;
      @(posedge pclk) disable iff (!presetn) post_pulse |-> match;
   endproperty
   a_match_post: assert property (p_match_post)
      else $error("postscaler pulse without a match");

endmodule

// file: tb/pmt_timer_test.sv
// Purpose: Self-checking bench for the period match timer over APB
// Assumes: Zero wait state slave; offsets and fields from pmt_defs.svh
// Notes: Reads are queued by the driver and checked by a monitor
`timescale 1ns/1ns
`include "pmt_defs.svh"
module pmt_timer_test;
   import pmt_pkg::*;
   logic pclk;
   logic presetn;
   logic psel;
   logic penable;
   logic pwrite;
   logic [7:0] paddr;
   logic [31:0] pwdata;
   logic pready;
   logic [31:0] prdata;
   logic pslverr;
   logic irq;
   logic [32:0] exp_q[$];
   logic [32:0] exp_v;
   int bad_count;
   int comparisons;
   int seed;

   pmt_timer #(.ADDR_W(8)) uut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pready(pready),
      .prdata(prdata),
      .pslverr(pslverr),
      .irq(irq)
   );

   // 100 MHz clock
   always #5 pclk = ~pclk;

   task automatic close_out();
      if (bad_count == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      $display("[FAIL] %0t %s", $time, msg);
      bad_count++;
   endtask

   // Read answers are compared against the oldest queued note
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         comparisons++;
         if (exp_q.size() == 0) begin
            fail("read answer with nothing expected");
         end else begin
            exp_v = exp_q.pop_front();
            if ({pslverr, prdata} !== exp_v) begin
               fail("read data or error mismatch");
            end
         end
      end
   end

   // One APB transfer; released once pready is seen high, or after 50 cycles without it
   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) begin
         fail("no pready");
         close_out();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic err);
      exp_q.push_back({err, d});
      apb(1'b0, a, 32'h0);
   endtask

   task automatic check(input logic ok, input string msg);
      comparisons++;
      if (ok !== 1'b1) begin
         fail(msg);
      end
   endtask

   // Level output looked at mid-cycle, once the launching edge settled
   task automatic check_irq(input logic exp, input string msg);
      @(negedge pclk);
      check(irq === exp, msg);
   endtask

   // Every register back at its reset value
   task automatic check_defaults();
      rd(`PMT_OFF_COUNT, 32'h00, 1'b0);
      rd(`PMT_OFF_LIMIT, 32'hff, 1'b0);
      rd(`PMT_OFF_CTRL, 32'h00, 1'b0);
      rd(`PMT_OFF_FLAG, 32'h00, 1'b0);
      rd(`PMT_OFF_MASK, 32'h00, 1'b0);
      check_irq(1'b0, "irq high after reset");
   endtask

   // Time from a control write to the flag, with count cleared first;
   // a little slack covers the register stage behind the flag
   task automatic period_case(input int pre, input int post, input int lim);
      int n;
      int t;
      t = 4 * (1 << (2 * pre)) * (lim + 1) * (post + 1);
      wr(`PMT_OFF_FLAG, 32'h1);
      wr(`PMT_OFF_LIMIT, lim);
      wr(`PMT_OFF_COUNT, 32'h0);
      wr(`PMT_OFF_CTRL, (post << 3) | 32'h4 | pre);
      n = 0;
      while (irq !== 1'b1 && n < 20000) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 20000) begin
         fail("flag never set");
         close_out();
      end
      check(n >= t - 1 && n <= t + 2, "flag period wrong");
      wr(`PMT_OFF_CTRL, 32'h0);
      rd(`PMT_OFF_FLAG, 32'h1, 1'b0);
   endtask

   initial begin
      logic [31:0] v;
      pclk = 1'b0;
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      bad_count = 0;
      comparisons = 0;
      seed = 32;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check_defaults();
      // Unmapped place is refused and a write there has no effect
      wr(8'h14, 32'hffffffff);
      rd(8'h14, 32'h0, 1'b1);
      rd(8'h84, 32'h0, 1'b1);
      // Count, limit and control read back; bit 7 of control reads 0
      for (int i = 0; i < 4; i++) begin
         v = $random(seed);
         wr(`PMT_OFF_LIMIT, v);
         rd(`PMT_OFF_LIMIT, {24'h0, v[7:0]}, 1'b0);
         wr(`PMT_OFF_COUNT, v >> 8);
         rd(`PMT_OFF_COUNT, {24'h0, v[15:8]}, 1'b0);
         wr(`PMT_OFF_CTRL, (v | 32'h80) & 32'hfb);
         rd(`PMT_OFF_CTRL, {24'h0, v[7:0] & 8'h7b}, 1'b0);
         rd(`PMT_OFF_COUNT, {24'h0, v[15:8]}, 1'b0);
      end
      // Run for eighteen cycles at 1:1: four increments, then held
      wr(`PMT_OFF_LIMIT, 32'hff);
      wr(`PMT_OFF_COUNT, 32'h0);
      wr(`PMT_OFF_CTRL, 32'h4);
      repeat (15) @(posedge pclk);
      wr(`PMT_OFF_CTRL, 32'h78);
      rd(`PMT_OFF_COUNT, 32'h4, 1'b0);
      repeat (100) @(posedge pclk);
      rd(`PMT_OFF_COUNT, 32'h4, 1'b0);
      rd(`PMT_OFF_FLAG, 32'h0, 1'b0);
      // Masked flag keeps irq low; mask and clear work on it
      wr(`PMT_OFF_LIMIT, 32'h0);
      wr(`PMT_OFF_COUNT, 32'h0);
      wr(`PMT_OFF_CTRL, 32'h4);
      repeat (40) @(posedge pclk);
      wr(`PMT_OFF_CTRL, 32'h0);
      check_irq(1'b0, "masked irq high");
      rd(`PMT_OFF_FLAG, 32'h1, 1'b0);
      wr(`PMT_OFF_MASK, 32'h1);
      check_irq(1'b1, "unmasked irq low");
      wr(`PMT_OFF_FLAG, 32'h1);
      check_irq(1'b0, "irq after clear");
      rd(`PMT_OFF_FLAG, 32'h0, 1'b0);
      // Every prescale code, postscale at both ends and between
      period_case(0, 15, 2);
      period_case(1, 1, 2);
      period_case(2, 2, 2);
      period_case(3, 0, 2);
      // Count write mid-interval clears the prescaler: full wait again
      wr(`PMT_OFF_FLAG, 32'h1);
      wr(`PMT_OFF_COUNT, 32'h0);
      wr(`PMT_OFF_CTRL, 32'h5);
      repeat (10) @(posedge pclk);
      wr(`PMT_OFF_COUNT, 32'h0);
      repeat (12) @(posedge pclk);
      wr(`PMT_OFF_CTRL, 32'h0);
      rd(`PMT_OFF_COUNT, 32'h0, 1'b0);
      // Reset in mid-run restores every default
      wr(`PMT_OFF_CTRL, 32'h4);
      repeat (30) @(posedge pclk);
      presetn <= 1'b0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      check_defaults();
      repeat (2) @(posedge pclk);
      check(exp_q.size() == 0, "reads left unanswered");
      close_out();
   end
endmodule
